//--- include/rss_consts.svh
// constants of the receive status snapshot block
// assumes: included by bare name, 32-bit axi4-lite register map
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSS_OFF_CTRL 8'h00
`define RSS_OFF_VALID 8'h04
`define RSS_OFF_ERROR 8'h08
`define RSS_OFF_LEVEL 8'h0c
`define RSS_OFF_STATE 8'h10
`define RSS_OFF_ALL 8'h14
// ----------------------------------------
// control fields
// ----------------------------------------
`define RSS_CTRL_SOR 0
`define RSS_CTRL_HOLD 1
`define RSS_CTRL_INV 2
`define RSS_CTRL_TRANSP 3
`define RSS_CTRL_PLEN_LO 4
`define RSS_CTRL_PLEN_HI 8
`define RSS_CTRL_RESET 32'h0000_0000
// ----------------------------------------
// preamble and response codes
// ----------------------------------------
`define RSS_PLEN_MAX 6'h20
`define RSS_RESP_OKAY 2'h0
`define RSS_RESP_SLVERR 2'h2
`endif

//--- include/rss_pkg.sv
// types of the receive status snapshot block
// assumes: used by scoped names only
package rss_pkg;
    // gray codes along idle, wakeup, preamble, data
    typedef enum logic [1:0] {
        RSS_IDLE = 2'h0,
        RSS_WAKE = 2'h1,
        RSS_PREA = 2'h3,
        RSS_DATA = 2'h2
    } rss_phase_t;
endpackage : rss_pkg

//--- hdl/rss_vote.sv
// manchester polarity vote counter and chip decoder
// assumes: chip_stb is a one-cycle pulse on mclk per received chip
`timescale 1ns/1ps
module rss_vote (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clr,
    input wire logic chip_stb,
    input wire logic chip,
    output logic [3:0] vote,
    output logic bit_out
);
    logic half_r;
    logic prev_r;
    logic seen_r;
    logic [3:0] vote_r;
    logic bit_r;

    // ----------------------------------------
    // bit-half tracking
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            half_r <= 1'b0;
            prev_r <= 1'b0;
            seen_r <= 1'b0;
        end else if (chip_stb) begin
            half_r <= ~half_r;
            prev_r <= chip;
            seen_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // vote: up at assumed boundary, down mid-bit
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            vote_r <= 4'h0;
        end else if (chip_stb && seen_r && (chip != prev_r)) begin
            if (!half_r && vote_r != 4'h7) begin
                vote_r <= vote_r + 4'h1;
            end else if (half_r && vote_r != 4'h8) begin
                vote_r <= vote_r - 4'h1;
            end
        end
    end

    // ----------------------------------------
    // decoded bit from the first chip half
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            bit_r <= 1'b0;
        end else if (chip_stb && half_r) begin
            bit_r <= prev_r;
        end
    end

    assign vote = vote_r;
    assign bit_out = bit_r;

    no_edge_a: assert property (@(posedge mclk) disable iff (srst)
        (chip_stb && seen_r && chip == prev_r && !clr) |=> $stable(vote_r))
        else $error("vote moved without a transition");
endmodule : rss_vote

//--- hdl/rss_top.sv
// receive status snapshot, phase pin control and axi4-lite registers
// assumes: monitor, level and phase inputs are on mclk; chip_clk and
// chip_data come from outside and are synchronised here
//
// How it works
// - three status registers load together
// - snapshot_on_read samples on every host read
// - wakeup end always samples status
// - reads leave status when snapshot_on_read clear
// - one sample at read start, adjacent words
// - wakeup end clears snapshot_on_read
// - level read rearms snapshot_on_read unless held
// - rearm hold keeps snapshot_on_read unchanged except by ctrl writes and wakeup end
// - error flag zero while valid flag zero
// - preamble length 1..32, zero means 32
// - preamble accepted after wakeup or standalone
// - pin low in wakeup, high in preamble
// - signed vote counter, up boundary, down mid
// - vote bit 3 flags inversion, zero without edges
// - data-only start has unknown bit-half alignment
// - optional inversion before the data pin
// - transparent mode routes slicer to pin
// - reception continues during host commands
// - wakeup end raises request, stores fail flag
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_top #(
    parameter int MONW = 6,
    parameter int LVLW = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [MONW-1:0] mon_valid,
    input wire logic [MONW-1:0] mon_error,
    input wire logic [LVLW-1:0] level,
    input wire logic wakeup_start,
    input wire logic wakeup_done,
    input wire logic wakeup_fail,
    input wire logic preamble_start,
    input wire logic preamble_done,
    input wire logic data_start,
    input wire logic rx_stop,
    input wire logic chip_clk,
    input wire logic chip_data,
    input wire logic slicer_data,
    output logic [5:0] preamble_chips,
    output logic wakeup_irq,
    output logic rx_data_pin
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [31:0] ctrl_r;
    logic [MONW-1:0] valid_r;
    logic [MONW-1:0] error_r;
    logic [LVLW-1:0] level_r;
    logic [MONW-1:0] valid_nxt;
    logic [MONW-1:0] error_nxt;
    logic [LVLW-1:0] level_nxt;
    logic fail_r;
    logic irq_r;
    logic pin_r;
    rss_pkg::rss_phase_t phase_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic ar_hs;
    logic wr_go;
    logic take;
    logic rd_level;
    logic ctrl_wr;
    logic [2:0] clk_sync_r;
    logic [1:0] dat_sync_r;
    logic [1:0] slc_sync_r;
    logic chip_stb;
    logic vote_clr;
    logic [3:0] vote;
    logic dec_bit;
    logic sor;
    logic [4:0] plen;

    assign sor = ctrl_r[`RSS_CTRL_SOR];
    assign plen = ctrl_r[`RSS_CTRL_PLEN_HI:`RSS_CTRL_PLEN_LO];

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign ctrl_wr = wr_go && (awaddr_r == `RSS_OFF_CTRL);

    always_ff @(posedge mclk) begin
        if (srst) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bvalid_r <= 1'b0;
            bresp_r <= `RSS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r == `RSS_OFF_CTRL) ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ----------------------------------------
    // status sampling
    // ----------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign take = wakeup_done || (ar_hs && sor);
    assign rd_level = ar_hs && ((s_axi_araddr == `RSS_OFF_LEVEL) ||
                                (s_axi_araddr == `RSS_OFF_ALL));

    always_comb begin
        valid_nxt = valid_r;
        error_nxt = error_r;
        level_nxt = level_r;
        if (take) begin
            valid_nxt = mon_valid;
            error_nxt = mon_error & mon_valid;
            level_nxt = level;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            valid_r <= '0;
            error_r <= '0;
            level_r <= '0;
        end else begin
            valid_r <= valid_nxt;
            error_r <= error_nxt;
            level_r <= level_nxt;
        end
    end

    // ----------------------------------------
    // control register and snapshot arming
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r <= `RSS_CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                for (int i = 0; i < 4; i++) begin
                    if (wstrb_r[i]) begin
                        ctrl_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
                    end
                end
            end
            if (rd_level && !ctrl_r[`RSS_CTRL_HOLD]) begin
                ctrl_r[`RSS_CTRL_SOR] <= 1'b1;
            end
            if (wakeup_done) begin
                ctrl_r[`RSS_CTRL_SOR] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // wakeup result and request
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            fail_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= wakeup_done;
            if (wakeup_done) begin
                fail_r <= wakeup_fail;
            end
        end
    end

    assign wakeup_irq = irq_r;

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RSS_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rresp_r <= `RSS_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            case (s_axi_araddr)
                `RSS_OFF_CTRL: rdata_r <= ctrl_r;
                `RSS_OFF_VALID: rdata_r[MONW-1:0] <= valid_nxt;
                `RSS_OFF_ERROR: rdata_r[MONW-1:0] <= error_nxt;
                `RSS_OFF_LEVEL: rdata_r[LVLW-1:0] <= level_nxt;
                `RSS_OFF_STATE: rdata_r[7:0] <= {vote, 1'b0, phase_r, fail_r};
                `RSS_OFF_ALL: rdata_r <= {8'h00, level_nxt, 2'h0, error_nxt,
                                          2'h0, valid_nxt};
                default: rresp_r <= `RSS_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------
    // chip link synchronisers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_sync_r <= 3'h0;
            dat_sync_r <= 2'h0;
            slc_sync_r <= 2'h0;
        end else begin
            clk_sync_r <= {clk_sync_r[1:0], chip_clk};
            dat_sync_r <= {dat_sync_r[0], chip_data};
            slc_sync_r <= {slc_sync_r[0], slicer_data};
        end
    end

    assign chip_stb = clk_sync_r[1] && !clk_sync_r[2] && (phase_r == rss_pkg::RSS_DATA);
    assign vote_clr = data_start || preamble_done;

    rss_vote rss_vote_inst (
        .mclk(mclk),
        .srst(srst),
        .clr(vote_clr),
        .chip_stb(chip_stb),
        .chip(dat_sync_r[1]),
        .vote(vote),
        .bit_out(dec_bit)
    );

    // ----------------------------------------
    // reception phases, unaffected by bus traffic
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            phase_r <= rss_pkg::RSS_IDLE;
        end else begin
            case (phase_r)
                rss_pkg::RSS_IDLE: begin
                    if (wakeup_start) begin
                        phase_r <= rss_pkg::RSS_WAKE;
                    end else if (preamble_start) begin
                        phase_r <= rss_pkg::RSS_PREA;
                    end else if (data_start) begin
                        phase_r <= rss_pkg::RSS_DATA;
                    end
                end
                rss_pkg::RSS_WAKE: begin
                    if (wakeup_done && wakeup_fail) begin
                        phase_r <= rss_pkg::RSS_IDLE;
                    end else if (wakeup_done) begin
                        phase_r <= preamble_start ? rss_pkg::RSS_PREA
                                                  : rss_pkg::RSS_IDLE;
                    end
                end
                rss_pkg::RSS_PREA: begin
                    if (rx_stop) begin
                        phase_r <= rss_pkg::RSS_IDLE;
                    end else if (preamble_done) begin
                        phase_r <= rss_pkg::RSS_DATA;
                    end
                end
                rss_pkg::RSS_DATA: begin
                    if (rx_stop) begin
                        phase_r <= rss_pkg::RSS_IDLE;
                    end
                end
                default: phase_r <= rss_pkg::RSS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // data pin
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_r <= 1'b0;
        end else if (ctrl_r[`RSS_CTRL_TRANSP]) begin
            pin_r <= slc_sync_r[1] ^ ctrl_r[`RSS_CTRL_INV];
        end else begin
            case (phase_r)
                rss_pkg::RSS_WAKE: pin_r <= 1'b0;
                rss_pkg::RSS_PREA: pin_r <= 1'b1;
                rss_pkg::RSS_DATA: pin_r <= dec_bit ^ ctrl_r[`RSS_CTRL_INV];
                default: pin_r <= 1'b0;
            endcase
        end
    end

    assign rx_data_pin = pin_r;
    assign preamble_chips = (plen == 5'h00) ? `RSS_PLEN_MAX : {1'b0, plen};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence host_read_armed;
        ar_hs && sor;
    endsequence

    coherent_load_a: assert property (@(posedge mclk) disable iff (srst)
        take |=> (valid_r == $past(mon_valid)) && (level_r == $past(level)))
        else $error("status set not loaded together");

    read_sample_a: assert property (@(posedge mclk) disable iff (srst)
        host_read_armed |=> error_r == ($past(mon_error) & $past(mon_valid)))
        else $error("armed read did not sample");

    wake_sample_a: assert property (@(posedge mclk) disable iff (srst)
        wakeup_done |=> level_r == $past(level))
        else $error("wakeup end did not sample");

    read_hold_a: assert property (@(posedge mclk) disable iff (srst)
        (ar_hs && !sor && !wakeup_done) |=> $stable(valid_r) && $stable(level_r))
        else $error("unarmed read changed status");

    wake_clear_a: assert property (@(posedge mclk) disable iff (srst)
        wakeup_done |=> !sor)
        else $error("wakeup end left sampling armed");

    level_rearm_a: assert property (@(posedge mclk) disable iff (srst)
        (rd_level && !ctrl_r[`RSS_CTRL_HOLD] && !wakeup_done) |=> sor)
        else $error("level read did not rearm");

    rearm_hold_a: assert property (@(posedge mclk) disable iff (srst)
        (ctrl_r[`RSS_CTRL_HOLD] && !ctrl_wr && !wakeup_done) |=> $stable(sor))
        else $error("held arming bit changed");

    error_mask_a: assert property (@(posedge mclk) disable iff (srst)
        (error_r & ~valid_r) == '0)
        else $error("error flag without valid flag");

    preamble_length_a: assert property (@(posedge mclk) disable iff (srst)
        preamble_chips >= 6'h01 && preamble_chips <= `RSS_PLEN_MAX)
        else $error("preamble length out of range");

    wake_pin_a: assert property (@(posedge mclk) disable iff (srst)
        (phase_r == rss_pkg::RSS_WAKE && !ctrl_r[`RSS_CTRL_TRANSP]) [*2]
        |-> !rx_data_pin)
        else $error("data pin not low in wakeup");

    irq_fail_a: assert property (@(posedge mclk) disable iff (srst)
        wakeup_done |=> wakeup_irq && (fail_r == $past(wakeup_fail)))
        else $error("wakeup result not reported");
endmodule : rss_top

//--- sim/rss_host.sv
// host model: axi4-lite master reaching the status block's registers
// assumes: one transfer at a time; tasks are called by the bench top
`timescale 1ns/1ps
module rss_host (
    input wire logic mclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // ----------------------------------------
    // bus transfers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // ----------------------------------------
    // host-side readings of status
    // ----------------------------------------
    function automatic logic [5:0] pass_mask(input logic [5:0] v, input logic [5:0] e);
        return v & ~e;
    endfunction : pass_mask

    function automatic logic is_inverted(input logic [3:0] vote);
        return vote[3];
    endfunction : is_inverted
endmodule : rss_host

//--- sim/rss_top_tb_top.sv
// bench for the receive status snapshot block
// assumes: rss_host drives the register bus, the bench drives the rest
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_top_tb_top;
    localparam logic [1:0] rsp_ok = `RSS_RESP_OKAY;
    localparam logic [1:0] rsp_err = `RSS_RESP_SLVERR;
    localparam logic [5:0] ev_ws = 6'h01, ev_wd = 6'h02, ev_ps = 6'h04;
    localparam logic [5:0] ev_pd = 6'h08, ev_ds = 6'h10, ev_stop = 6'h20;
    logic mclk = 1'b0, srst = 1'b1, wakeup_fail = 1'b0;
    logic chip_clk = 1'b0, chip_data = 1'b0, slicer_data = 1'b0;
    logic [5:0] ev = 6'h00, mon_valid = 6'h00, mon_error = 6'h00;
    logic [7:0] level = 8'h00, awaddr, araddr;
    logic [5:0] preamble_chips;
    logic wakeup_irq, rx_data_pin, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int bad_count = 0, comparisons = 0, cycles = 0;

    always #5 mclk = ~mclk;

    rss_top rss_top_inst (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mon_valid(mon_valid), .mon_error(mon_error), .level(level),
        .wakeup_start(ev[0]), .wakeup_done(ev[1]), .wakeup_fail(wakeup_fail),
        .preamble_start(ev[2]), .preamble_done(ev[3]), .data_start(ev[4]), .rx_stop(ev[5]),
        .chip_clk(chip_clk), .chip_data(chip_data), .slicer_data(slicer_data),
        .preamble_chips(preamble_chips), .wakeup_irq(wakeup_irq), .rx_data_pin(rx_data_pin));

    rss_host rss_host_inst (.mclk(mclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rss_host_inst.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rdc

    task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic [1:0] r;
        rss_host_inst.wr(a, v, r);
        chk({30'h0, r}, {30'h0, er});
    endtask : wrc

    task automatic pulse(input logic [5:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 6'h00;
    endtask : pulse

    task automatic set_mon(input logic [5:0] v, input logic [5:0] e, input logic [7:0] l);
        mon_valid <= v;
        mon_error <= e;
        level <= l;
    endtask : set_mon

    task automatic pin_chk(input logic e);
        repeat (6) @(posedge mclk);
        chk({31'h0, rx_data_pin}, {31'h0, e});
    endtask : pin_chk

    // eight chips at an 80 ns chip clock, first chip in bit 7
    task automatic send(input logic [7:0] s);
        @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            chip_data <= s[7 - i];
            repeat (4) @(posedge mclk);
            chip_clk <= 1'b1;
            repeat (4) @(posedge mclk);
            chip_clk <= 1'b0;
        end
    endtask : send

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_snapshot();
        set_mon(6'h2d, 6'h33, 8'ha5);
        rdc(`RSS_OFF_CTRL, `RSS_CTRL_RESET, rsp_ok);
        rdc(8'h18, 32'h0, rsp_err);
        wrc(`RSS_OFF_VALID, 32'h3f, rsp_err);
        rdc(`RSS_OFF_VALID, 32'h0, rsp_ok);
        wrc(`RSS_OFF_CTRL, 32'h3, rsp_ok);
        rdc(`RSS_OFF_VALID, 32'h2d, rsp_ok);
        rdc(`RSS_OFF_ERROR, 32'h21, rsp_ok);
        wrc(`RSS_OFF_CTRL, 32'h2, rsp_ok);
        set_mon(6'h12, 6'h3f, 8'h5a);
        rdc(`RSS_OFF_LEVEL, 32'ha5, rsp_ok);
        rdc(`RSS_OFF_CTRL, 32'h2, rsp_ok);
        wrc(`RSS_OFF_CTRL, 32'h0, rsp_ok);
        rdc(`RSS_OFF_LEVEL, 32'ha5, rsp_ok);
        rdc(`RSS_OFF_CTRL, 32'h1, rsp_ok);
        rdc(`RSS_OFF_ALL, 32'h005a_1212, rsp_ok);
    endtask : t_snapshot

    task automatic t_wakeup();
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
        set_mon(6'h0f, 6'h3c, 8'h77);
        pulse(ev_ws);
        wakeup_fail <= 1'b1;
        pulse(ev_wd);
        set_mon(6'h30, 6'h00, 8'h11);
        #1;
        chk({31'h0, wakeup_irq}, 32'h1);
        rdc(`RSS_OFF_CTRL, 32'h0, rsp_ok);
        rss_host_inst.rd(`RSS_OFF_VALID, d, r);
        rss_host_inst.rd(`RSS_OFF_ERROR, e, r);
        chk({26'h0, rss_host_inst.pass_mask(d[5:0], e[5:0])}, 32'h3);
        rdc(`RSS_OFF_ALL, 32'h0077_0c0f, rsp_ok);
        rdc(`RSS_OFF_STATE, 32'h1, rsp_ok);
    endtask : t_wakeup

    task automatic t_plen();
        logic [4:0] f [4] = '{5'h00, 5'h01, 5'h10, 5'h1f};
        for (int i = 0; i < 4; i++) begin
            wrc(`RSS_OFF_CTRL, {23'h0, f[i], 4'h0}, rsp_ok);
            chk({26'h0, preamble_chips}, (f[i] == 5'h0) ? 32'h20 : {27'h0, f[i]});
        end
    endtask : t_plen

    task automatic t_phases();
        wrc(`RSS_OFF_CTRL, 32'h0, rsp_ok);
        pulse(ev_ps);
        pin_chk(1'b1);
        rdc(`RSS_OFF_STATE, 32'h7, rsp_ok);
        pulse(ev_stop);
        pulse(ev_ws);
        pin_chk(1'b0);
        rdc(`RSS_OFF_STATE, 32'h3, rsp_ok);
        wakeup_fail <= 1'b0;
        pulse(ev_wd | ev_ps);
        pin_chk(1'b1);
        pulse(ev_pd);
        rdc(`RSS_OFF_STATE, 32'h4, rsp_ok);
        wrc(`RSS_OFF_CTRL, 32'h8, rsp_ok);
        slicer_data <= 1'b1;
        pin_chk(1'b1);
        wrc(`RSS_OFF_CTRL, 32'hc, rsp_ok);
        pin_chk(1'b0);
        wrc(`RSS_OFF_CTRL, 32'h0, rsp_ok);
        slicer_data <= 1'b0;
    endtask : t_phases

    task automatic t_vote();
        logic [31:0] d;
        logic [1:0] r;
        pulse(ev_stop);
        pulse(ev_ds);
        fork
            send(8'h3c);
            rdc(`RSS_OFF_CTRL, 32'h0, rsp_ok);
        join
        repeat (8) @(posedge mclk);
        rdc(`RSS_OFF_STATE, 32'h24, rsp_ok);
        rss_host_inst.rd(`RSS_OFF_STATE, d, r);
        chk({31'h0, rss_host_inst.is_inverted(d[7:4])}, 32'h0);
        pin_chk(1'b0);
        wrc(`RSS_OFF_CTRL, 32'h4, rsp_ok);
        pin_chk(1'b1);
        wrc(`RSS_OFF_CTRL, 32'h0, rsp_ok);
        pulse(ev_stop);
        pulse(ev_ds);
        send(8'h66);
        repeat (8) @(posedge mclk);
        rdc(`RSS_OFF_STATE, 32'hc4, rsp_ok);
        rss_host_inst.rd(`RSS_OFF_STATE, d, r);
        chk({31'h0, rss_host_inst.is_inverted(d[7:4])}, 32'h1);
    endtask : t_vote

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_snapshot();
        t_wakeup();
        t_plen();
        t_phases();
        t_vote();
        tally_and_finish();
    end
endmodule : rss_top_tb_top
